// ===== core/ir_remote_key_encoder.sv
// How it works
// - Standby: oscillator off, strobes low, custom pins high.
// - Standby after reset and after an empty scan with the transmitter idle.
// - Any low sense input wakes and restarts oscillator.
// - Four strobes by eight senses give keys 1-32.
// - Key 21 with 22/23/24 sends 35h/36h/37h.
// - Bursts carry oscillator/12 carrier, one third high.
// - Frames repeat at frame interval while key held.
// - Repetitions send 9ms plus 4.5ms repeat code.
// - Custom-code pin levels select the frame custom code.
// - Low reset holds the block; release restarts cleanly.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Flip-flop FIFO with valid and ready on both sides.
module ir_fifo #(
   parameter int unsigned WIDTH = 17,
   parameter int unsigned DEPTH = 32
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int unsigned AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];  // Storage words.
   logic [AW:0]      wr_q;           // Write index with wrap bit.
   logic [AW:0]      rd_q;           // Read index with wrap bit.
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;

   // Full when the indexes differ only in the wrap bit, empty when equal.
   assign in_ready  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
   assign out_valid = (wr_q != rd_q);
   assign out_data  = mem_q[rd_q[AW-1:0]];

   // Index update.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_q <= '0;
         rd_q <= '0;
      end
      else
      begin
         if (push) wr_q <= wr_q + 1'b1;
         if (pop)  rd_q <= rd_q + 1'b1;
      end
   end

   // Storage write; contents need no reset.
   always_ff @(posedge clk)
   begin
      if (push) mem_q[wr_q[AW-1:0]] <= in_data;
   end
endmodule : ir_fifo

////////////////////////////////////////////////////////////////////////////////
// Key matrix scanner and infrared frame transmitter.
module ir_remote_key_encoder
   import ir_pkg::*;
#(
   parameter int unsigned REP_MARK_T   = REP_MARK_US,   // Repeat burst, microseconds.
   parameter int unsigned REP_SPACE_T  = REP_SPACE_US,  // Repeat space, microseconds.
   parameter int unsigned LEAD_MARK_T  = LEAD_MARK_US,  // Leader burst, microseconds.
   parameter int unsigned LEAD_SPACE_T = LEAD_SPACE_US, // Leader space, microseconds.
   parameter int unsigned FRAME_T      = FRAME_US       // Frame interval, microseconds.
) (
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic sense_in_0,
   input  wire logic sense_in_1,
   input  wire logic sense_in_2,
   input  wire logic sense_in_3,
   input  wire logic sense_in_4,
   input  wire logic sense_in_5,
   input  wire logic sense_in_6,
   input  wire logic sense_in_7,
   output logic      scan_strobe_0,
   output logic      scan_strobe_1,
   output logic      scan_strobe_2,
   output logic      scan_strobe_3,
   input  wire logic custom_sel_low_pin,
   output logic      custom_sel_low_drive,
   output logic      custom_sel_low_oe,
   input  wire logic custom_sel_high_pin,
   output logic      custom_sel_high_drive,
   output logic      custom_sel_high_oe,
   output logic      ir_transmit_out,
   output logic      osc_running
);

   ////////////////////////////////////////////////////////////////////////////
   // Functions.

   // Key code of a scan map; double combinations win over single keys.
   function automatic logic [7:0] key_code(input logic [KEYS-1:0] map);
      logic [7:0] code;
      code = 8'h00;
      for (int i = KEYS - 1; i >= 0; i--)
         if (map[i]) code = 8'(i);
      if (map[SHIFT_KEY_IDX] && map[SHIFT_KEY_IDX+3]) code = CODE_24;
      if (map[SHIFT_KEY_IDX] && map[SHIFT_KEY_IDX+2]) code = CODE_23;
      if (map[SHIFT_KEY_IDX] && map[SHIFT_KEY_IDX+1]) code = CODE_22;
      return code;
   endfunction : key_code

   // Phase end test for a microsecond timer against a duration.
   function automatic logic time_up(input logic [16:0] t, input logic [16:0] dur);
      return (t >= dur - 17'd1);
   endfunction : time_up

   ////////////////////////////////////////////////////////////////////////////
   // Reset release and input synchronisers.
   logic [1:0]         rst_sync_q;     // Reset release pipeline.
   wire                rst_n_s = rst_sync_q[1];
   logic [SENSES-1:0]  sense_meta_q;   // First stage, read only by the second.
   logic [SENSES-1:0]  sense_q;        // Synchronised sense levels.
   logic [1:0]         sel_meta_q;     // First stage of the custom pins.
   logic [1:0]         sel_q;          // Synchronised custom selection.
   wire  [SENSES-1:0]  sense_raw = {sense_in_7, sense_in_6, sense_in_5, sense_in_4,
                                    sense_in_3, sense_in_2, sense_in_1, sense_in_0};

   // Reset is taken at once and released through two flops.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn) rst_sync_q <= 2'b00;
      else       rst_sync_q <= {rst_sync_q[0], 1'b1};
   end

   // Pins cross into the clock domain through two flops.
   always_ff @(posedge clk or negedge rst_n_s)
   begin
      if (!rst_n_s)
      begin
         sense_meta_q <= '1;
         sense_q      <= '1;
         sel_meta_q   <= 2'b11;
         sel_q        <= 2'b11;
      end
      else
      begin
         sense_meta_q <= sense_raw;
         sense_q      <= sense_meta_q;
         sel_meta_q   <= {custom_sel_high_pin, custom_sel_low_pin};
         sel_q        <= sel_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Oscillator model: the microsecond tick runs only while awake.
   logic        osc_q;          // Oscillator running.
   logic [4:0]  us_div_q;       // Microsecond divider.
   wire         us_tick = osc_q && (us_div_q == 5'(US_CYC - 1));

   // Divider stops with the oscillator.
   always_ff @(posedge clk or negedge rst_n_s)
   begin
      if (!rst_n_s)      us_div_q <= '0;
      else if (!osc_q)   us_div_q <= '0;
      else if (us_tick)  us_div_q <= '0;
      else               us_div_q <= us_div_q + 5'd1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Scanner.
   scan_state_e       scan_q;       // Scanner state.
   logic [1:0]        strobe_idx_q; // Strobe being driven.
   logic [5:0]        settle_q;     // Settle counter.
   logic [KEYS-1:0]   map_q;        // Keys found in this scan.
   logic              held_q;       // A key is being transmitted.
   logic [16:0]       intv_q;       // Microseconds since last frame push.
   logic [FIFO_W-1:0] word_q;       // Word offered to the buffer.
   logic [3:0]        strobe_q;     // Strobe pins, active low.
   logic              sel_oe_q;     // Custom pins driven high.
   wire               fifo_in_ready;
   wire               tx_idle;
   wire               any_key    = |map_q;
   wire               intv_done  = (intv_q >= 17'(FRAME_T - 1));
   wire               settled    = (settle_q == 6'(SETTLE_CYC - 1));
   wire               any_sense  = |(~sense_q);
   wire  [7:0]        custom     = CUSTOM_BASE + {6'h00, sel_q};
   wire  [7:0]        code       = key_code(map_q);

   // Scan sequence, standby entry and frame scheduling.
   always_ff @(posedge clk or negedge rst_n_s)
   begin
      if (!rst_n_s)
      begin
         scan_q       <= SCAN_SLEEP;
         osc_q        <= 1'b0;
         strobe_idx_q <= '0;
         settle_q     <= '0;
         map_q        <= '0;
         held_q       <= 1'b0;
         word_q       <= '0;
         strobe_q     <= 4'h0;
         sel_oe_q     <= 1'b1;
      end
      else
      begin
         unique case (scan_q)
            // Asleep: strobes low so any key pulls its sense line low.
            SCAN_SLEEP:
            begin
               strobe_q <= 4'h0;
               sel_oe_q <= 1'b1;
               if (any_sense)
               begin
                  scan_q       <= SCAN_STROBE;
                  osc_q        <= 1'b1;
                  sel_oe_q     <= 1'b0;
                  strobe_idx_q <= '0;
                  settle_q     <= '0;
                  map_q        <= '0;
                  strobe_q     <= 4'he;
               end
            end
            // One strobe low at a time; sample its eight senses once settled.
            SCAN_STROBE:
            begin
               settle_q <= settle_q + 6'd1;
               if (settled)
               begin
                  map_q[strobe_idx_q*SENSES +: SENSES] <= ~sense_q;
                  settle_q     <= '0;
                  strobe_idx_q <= strobe_idx_q + 2'd1;
                  strobe_q     <= ~(4'h1 << (strobe_idx_q + 2'd1));
                  if (strobe_idx_q == 2'(STROBES - 1))
                  begin
                     scan_q   <= SCAN_DECIDE;
                     strobe_q <= 4'hf;
                  end
               end
            end
            // A full scan is over: sleep, send, repeat or rescan.
            SCAN_DECIDE:
            begin
               strobe_idx_q <= '0;
               strobe_q     <= 4'he;
               scan_q       <= SCAN_STROBE;
               if (!any_key)
               begin
                  held_q <= 1'b0;
                  if (tx_idle)
                  begin
                     scan_q   <= SCAN_SLEEP;
                     osc_q    <= 1'b0;
                     strobe_q <= 4'h0;
                     sel_oe_q <= 1'b1;
                  end
               end
               else if (!held_q)
               begin
                  word_q <= {1'b0, code, custom};
                  held_q <= 1'b1;
                  scan_q <= SCAN_PUSH;
               end
               else if (intv_done)
               begin
                  word_q <= {1'b1, code, custom};
                  scan_q <= SCAN_PUSH;
               end
               map_q <= '0;
            end
            // Hold the word until the buffer takes it; a full buffer stalls scanning.
            SCAN_PUSH:
            begin
               if (fifo_in_ready) scan_q <= SCAN_STROBE;
            end
         endcase
      end
   end

   // Frame interval timer restarts when a frame is handed over.
   always_ff @(posedge clk or negedge rst_n_s)
   begin
      if (!rst_n_s)                                  intv_q <= '0;
      else if (scan_q == SCAN_PUSH && fifo_in_ready) intv_q <= '0;
      else if (us_tick && !intv_done)                intv_q <= intv_q + 17'd1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Buffer.
   wire [FIFO_W-1:0] fifo_out_data;
   wire              fifo_out_valid;

   ir_fifo #(
      .WIDTH (FIFO_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n_s),
      .in_data   (word_q),
      .in_valid  (scan_q == SCAN_PUSH),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_out_data),
      .out_valid (fifo_out_valid),
      .out_ready (tx_idle)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Transmitter.
   tx_state_e   tx_q;        // Transmitter state.
   logic        rep_q;       // Sending a repeat code.
   logic [15:0] shift_q;     // Remaining frame bits, LSB first.
   logic [4:0]  bit_cnt_q;   // Bits sent.
   logic [16:0] tmr_q;       // Microseconds in the current phase.
   logic [16:0] dur_q;       // Length of the current phase.
   logic [9:0]  car_q;       // Carrier phase counter.
   logic        out_q;       // Registered transmit output.
   wire         phase_end = us_tick && time_up(tmr_q, dur_q);
   wire         mark      = (tx_q == TX_LEAD_MARK) || (tx_q == TX_BIT_MARK) ||
                            (tx_q == TX_STOP_MARK);
   wire         last_bit  = (bit_cnt_q == 5'(FRAME_BITS - 1));
   assign tx_idle = (tx_q == TX_IDLE);

   // Frame sequencing; each phase lasts dur_q microsecond ticks.
   always_ff @(posedge clk or negedge rst_n_s)
   begin
      if (!rst_n_s)
      begin
         tx_q      <= TX_IDLE;
         rep_q     <= 1'b0;
         shift_q   <= '0;
         bit_cnt_q <= '0;
         tmr_q     <= '0;
         dur_q     <= '0;
      end
      else
      begin
         if (us_tick) tmr_q <= tmr_q + 17'd1;
         if (phase_end) tmr_q <= '0;
         unique case (tx_q)
            TX_IDLE:
            begin
               tmr_q <= '0;
               if (fifo_out_valid)
               begin
                  rep_q     <= fifo_out_data[FIFO_W-1];
                  shift_q   <= fifo_out_data[15:0];
                  bit_cnt_q <= '0;
                  tx_q      <= TX_LEAD_MARK;
                  dur_q     <= fifo_out_data[FIFO_W-1] ? 17'(REP_MARK_T) : 17'(LEAD_MARK_T);
               end
            end
            TX_LEAD_MARK:
               if (phase_end)
               begin
                  tx_q  <= TX_LEAD_SPACE;
                  dur_q <= rep_q ? 17'(REP_SPACE_T) : 17'(LEAD_SPACE_T);
               end
            TX_LEAD_SPACE:
               if (phase_end)
               begin
                  tx_q  <= rep_q ? TX_STOP_MARK : TX_BIT_MARK;
                  dur_q <= 17'(BIT_MARK_US);
               end
            TX_BIT_MARK:
               if (phase_end)
               begin
                  tx_q  <= TX_BIT_SPACE;
                  dur_q <= shift_q[0] ? 17'(ONE_SPACE_US) : 17'(ZERO_SPACE_US);
               end
            TX_BIT_SPACE:
               if (phase_end)
               begin
                  shift_q   <= {1'b0, shift_q[15:1]};
                  bit_cnt_q <= bit_cnt_q + 5'd1;
                  tx_q      <= last_bit ? TX_STOP_MARK : TX_BIT_MARK;
                  dur_q     <= 17'(BIT_MARK_US);
               end
            TX_STOP_MARK:
               if (phase_end) tx_q <= TX_IDLE;
         endcase
      end
   end

   // Carrier runs only inside bursts; output is low outside them.
   always_ff @(posedge clk or negedge rst_n_s)
   begin
      if (!rst_n_s)
      begin
         car_q <= '0;
         out_q <= 1'b0;
      end
      else
      begin
         if (!mark || car_q == 10'(CAR_CYC - 1)) car_q <= '0;
         else                                    car_q <= car_q + 10'd1;
         out_q <= mark && (car_q < 10'(CAR_HIGH_CYC));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, all from flops.
   assign scan_strobe_0         = strobe_q[0];
   assign scan_strobe_1         = strobe_q[1];
   assign scan_strobe_2         = strobe_q[2];
   assign scan_strobe_3         = strobe_q[3];
   assign custom_sel_low_drive  = sel_oe_q;
   assign custom_sel_low_oe     = sel_oe_q;
   assign custom_sel_high_drive = sel_oe_q;
   assign custom_sel_high_oe    = sel_oe_q;
   assign ir_transmit_out       = out_q;
   assign osc_running           = osc_q;

endmodule : ir_remote_key_encoder

// ===== core/ir_pkg.sv
// Shared constants and state types of the remote-control key encoder.
package ir_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Clock, oscillator and carrier.
   localparam int unsigned CLK_HZ        = 25_000_000;   // System clock rate.
   localparam int unsigned OSC_FREQ_HZ   = 455_000;      // Resonator oscillator_frequency.
   localparam int unsigned CAR_DIVIDE    = 12;           // Oscillator to carrier divide.
   localparam int unsigned CAR_HIGH_NUM  = 1;            // Carrier high time numerator.
   localparam int unsigned CAR_HIGH_DEN  = 3;            // Carrier high time denominator.
   // One carrier_frequency period in clock cycles, rounded down.
   localparam int unsigned CAR_CYC       = (CLK_HZ * CAR_DIVIDE) / OSC_FREQ_HZ;
   // Carrier high time in clock cycles, rounded down.
   localparam int unsigned CAR_HIGH_CYC  = (CAR_CYC * CAR_HIGH_NUM) / CAR_HIGH_DEN;
   localparam int unsigned US_PER_S      = 1_000_000;    // Microseconds in a second.
   localparam int unsigned US_CYC        = CLK_HZ / US_PER_S; // Cycles per microsecond tick.

   ////////////////////////////////////////////////////////////////////////////
   // Frame timing in microseconds; the leader, repeat and frame values are defaults of top parameters.
   localparam int unsigned REP_MARK_US   = 9000;    // Repeat code burst.
   localparam int unsigned REP_SPACE_US  = 4500;    // Repeat code space.
   localparam int unsigned LEAD_MARK_US  = 9000;    // Leader burst of a first frame.
   localparam int unsigned LEAD_SPACE_US = 4500;    // Leader space of a first frame.
   localparam int unsigned BIT_MARK_US   = 560;     // Burst in front of each bit.
   localparam int unsigned ZERO_SPACE_US = 560;     // Space that encodes a zero.
   localparam int unsigned ONE_SPACE_US  = 1690;    // Space that encodes a one.
   localparam int unsigned FRAME_US      = 108000;  // The frame_interval.

   ////////////////////////////////////////////////////////////////////////////
   // Key matrix.
   localparam int unsigned STROBES       = 4;       // Scan strobe outputs.
   localparam int unsigned SENSES        = 8;       // Key sense inputs.
   localparam int unsigned KEYS          = STROBES * SENSES;
   localparam int unsigned SETTLE_CYC    = 32;      // Strobe settle time before sampling.
   localparam int unsigned SHIFT_KEY_IDX = 20;      // Index of shift_key, key 21.
   localparam logic [7:0]  CODE_22       = 8'h35;   // Key 21 with key 22.
   localparam logic [7:0]  CODE_23       = 8'h36;   // Key 21 with key 23.
   localparam logic [7:0]  CODE_24       = 8'h37;   // Key 21 with key 24.
   localparam logic [7:0]  CUSTOM_BASE   = 8'h00;   // Custom code for selection 0.
   localparam int unsigned FRAME_BITS    = 16;      // Custom byte then key byte.

   ////////////////////////////////////////////////////////////////////////////
   // Buffer between scanner and transmitter: {repeat, key, custom}.
   localparam int unsigned FIFO_W        = 17;
   localparam int unsigned FIFO_DEPTH    = 32;

   ////////////////////////////////////////////////////////////////////////////
   // State types.
   typedef enum logic [3:0] {
      SCAN_SLEEP  = 4'b0001,
      SCAN_STROBE = 4'b0010,
      SCAN_DECIDE = 4'b0100,
      SCAN_PUSH   = 4'b1000
   } scan_state_e;

   typedef enum logic [5:0] {
      TX_IDLE       = 6'b000001,
      TX_LEAD_MARK  = 6'b000010,
      TX_LEAD_SPACE = 6'b000100,
      TX_BIT_MARK   = 6'b001000,
      TX_BIT_SPACE  = 6'b010000,
      TX_STOP_MARK  = 6'b100000
   } tx_state_e;

endpackage : ir_pkg

// ===== testbench/ir_remote_key_encoder_sva.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////
// Port checks of the key encoder, all on the one clock.
module ir_encoder_checker
   import ir_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic sense_in_0,
   input wire logic sense_in_1,
   input wire logic sense_in_2,
   input wire logic sense_in_3,
   input wire logic sense_in_4,
   input wire logic sense_in_5,
   input wire logic sense_in_6,
   input wire logic sense_in_7,
   input wire logic scan_strobe_0,
   input wire logic scan_strobe_1,
   input wire logic scan_strobe_2,
   input wire logic scan_strobe_3,
   input wire logic custom_sel_low_drive,
   input wire logic custom_sel_low_oe,
   input wire logic custom_sel_high_drive,
   input wire logic custom_sel_high_oe,
   input wire logic ir_transmit_out,
   input wire logic osc_running
);
   wire logic [3:0]  strobes = {scan_strobe_3, scan_strobe_2, scan_strobe_1, scan_strobe_0};
   wire logic        key_low = !(&{sense_in_7, sense_in_6, sense_in_5, sense_in_4, sense_in_3,
                                  sense_in_2, sense_in_1, sense_in_0});
   logic      [3:0]  age_q;  // Cycles since reset release, saturating.
   logic      [15:0] hi_q;   // Length so far of the current high run.
   logic      [15:0] gap_q;  // Cycles since the last rise, saturating.

   // Helper counters for the wake and carrier checks.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         age_q <= 4'h0;
         hi_q  <= 16'h0;
         gap_q <= 16'hffff;
      end
      else
      begin
         age_q <= (age_q == 4'hf) ? age_q : age_q + 4'h1;
         hi_q  <= ir_transmit_out ? hi_q + 16'h1 : 16'h0;
         gap_q <= $rose(ir_transmit_out) ? 16'h1 : gap_q + {15'h0, gap_q != 16'hffff};
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   // A key held low for three cycles while asleep, once reset has settled.
   sequence s_key_held;
      (age_q == 4'hf) && !osc_running && key_low ##1 key_low [*2];
   endsequence

   a_standby_pins:
      assert property (!osc_running |-> strobes == 4'h0 && custom_sel_low_oe && custom_sel_high_oe
         && custom_sel_low_drive && custom_sel_high_drive) else $error("Standby pins wrong.");
   a_sleep_after_scan:
      assert property ($fell(osc_running) |-> $past(strobes) == 4'hf) else $error("Early sleep.");
   a_wake_on_key:
      assert property (s_key_held |-> ##[0:3] osc_running) else $error("No wake on key.");
   a_strobe_hold:
      assert property ($fell(scan_strobe_2) && osc_running |-> ##32 $rose(scan_strobe_2))
         else $error("Strobe held for a wrong time.");
   a_one_strobe:
      assert property (osc_running |-> $countones(strobes) >= 3) else $error("Two strobes low.");
   a_straps_released:
      assert property (osc_running |-> !custom_sel_low_oe && !custom_sel_high_oe)
         else $error("Straps still driven while awake.");
   a_carrier_high:
      assert property (ir_transmit_out |-> hi_q < CAR_HIGH_CYC) else $error("Carrier high too long.");
   a_carrier_period:
      assert property ($rose(ir_transmit_out) |-> gap_q >= CAR_CYC) else $error("Carrier too fast.");
   a_dark_asleep:
      assert property (!osc_running |-> !ir_transmit_out) else $error("Output lit while asleep.");
endmodule : ir_encoder_checker

bind ir_remote_key_encoder ir_encoder_checker ir_encoder_checker_i (.*);

// ===== testbench/ir_key_pad.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////
// Passive key pad: a held key joins its sense line to its strobe.
module ir_key_pad (
   input  wire logic [31:0] pressed,
   input  wire logic [3:0]  strobe,
   output logic      [7:0]  sense
);
   // Sense lines rest high on pull-ups; a key on a low strobe pulls one down.
   always_comb
   begin
      sense = 8'hff;
      for (int k = 0; k < 32; k++)
         if (pressed[k] && !strobe[k / 8])
            sense[k % 8] = 1'b0;
   end
endmodule : ir_key_pad

// ===== testbench/ir_remote_key_encoder_tb.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////
// Bench: key pad model and encoder.
module ir_remote_key_encoder_tb
   import ir_pkg::*;
();
   localparam int unsigned MARK_T  = 40;     // Shortened bursts, microseconds.
   localparam int unsigned SPACE_T = 20;     // Shortened spaces, microseconds.
   localparam int unsigned LIMIT   = 90000;  // Cycle ceiling of the run.
   logic              clk = 1'b0;
   logic              rstn = 1'b0;
   logic       [31:0] pressed = 32'h0;      // Bit k holds key k+1 down.
   logic       [1:0]  jumper = 2'b00;       // Custom straps, {high, low}.
   wire  logic [7:0]  sense;
   wire  logic [3:0]  strobes;
   logic              lo_drv, lo_oe, hi_drv, hi_oe, ir_out, osc_on;
   wire  logic        lo_pin = lo_oe ? (lo_drv & jumper[0]) : jumper[0]; // Strap and drive join.
   wire  logic        hi_pin = hi_oe ? (hi_drv & jumper[1]) : jumper[1];
   logic              out_q = 1'b0;
   logic       [7:0]  custom;
   int unsigned       starts[$];            // Cycles at which bursts began.
   int unsigned       cyc = 0;
   int unsigned       last_fall = 0;
   int unsigned       err_count = 0;
   int unsigned       num_checks = 0;
   int unsigned       n, t0;

   always #20 clk = ~clk;

   ir_remote_key_encoder #(.REP_MARK_T(MARK_T), .REP_SPACE_T(SPACE_T), .LEAD_MARK_T(MARK_T),
      .LEAD_SPACE_T(SPACE_T), .FRAME_T(2000)) ir_remote_key_encoder_i (
      .clk(clk), .rstn(rstn), .sense_in_0(sense[0]), .sense_in_1(sense[1]),
      .sense_in_2(sense[2]), .sense_in_3(sense[3]), .sense_in_4(sense[4]),
      .sense_in_5(sense[5]), .sense_in_6(sense[6]), .sense_in_7(sense[7]),
      .scan_strobe_0(strobes[0]), .scan_strobe_1(strobes[1]), .scan_strobe_2(strobes[2]),
      .scan_strobe_3(strobes[3]), .custom_sel_low_pin(lo_pin), .custom_sel_low_drive(lo_drv),
      .custom_sel_low_oe(lo_oe), .custom_sel_high_pin(hi_pin), .custom_sel_high_drive(hi_drv),
      .custom_sel_high_oe(hi_oe), .ir_transmit_out(ir_out), .osc_running(osc_on));
   ir_key_pad ir_key_pad_i (.pressed(pressed), .strobe(strobes), .sense(sense));

   task automatic chk_pin(string what, logic exp, logic got);
      num_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("BAD %s expected %0b seen %0b", what, exp, got);
      end
   endtask : chk_pin

   // Compares with a slack of tol; unknown bits fail.
   task automatic chk_word(string what, logic [31:0] exp, logic [31:0] got, int unsigned tol);
      num_checks++;
      if ((got + tol >= exp && got <= exp + tol) !== 1'b1)
      begin
         err_count++;
         $display("BAD %s expected %0d seen %0d", what, exp, got);
      end
   endtask : chk_word

   task automatic final_report();
      if (err_count == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : final_report

   // Gap after burst idx: the leader, or custom bit idx-1.
   function automatic int unsigned gap_cyc(int unsigned idx, logic [7:0] code);
      if (idx == 0)
         return (MARK_T + SPACE_T) * US_CYC;
      return (BIT_MARK_US + (code[idx - 1] ? ONE_SPACE_US : ZERO_SPACE_US)) * US_CYC;
   endfunction : gap_cyc

   // Logs burst starts after a long low stretch; ends a hung run.
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      out_q <= ir_out;
      if (ir_out === 1'b1 && out_q === 1'b0 && (last_fall == 0 || cyc - last_fall > 500))
         starts.push_back(cyc);
      if (ir_out === 1'b0 && out_q === 1'b1)
         last_fall <= cyc;
      if (cyc == LIMIT)
      begin
         err_count++;
         final_report();
      end
   end

   initial
   begin
      void'($urandom(32'h6434));
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      // Asleep after reset with no key down.
      chk_pin("awake", 1'b0, osc_on);
      chk_word("strobes", 32'h0, 32'(strobes), 0);
      chk_pin("straps driven", 1'b1, lo_oe & hi_oe & lo_drv & hi_drv);
      // A short tap wakes a scan that finds nothing, then sleeps.
      pressed <= 32'h1 << $urandom_range(31);
      repeat (6) @(posedge clk);
      chk_pin("awake", 1'b1, osc_on);
      pressed <= 32'h0;
      for (n = 0; n < 300 && osc_on !== 1'b0; n++) @(posedge clk);
      chk_pin("asleep", 1'b0, osc_on);
      chk_pin("no burst", 1'b1, starts.size() == 0);
      // Held key, random straps: leader, then the lowest custom bit.
      n = $urandom_range(3);
      jumper <= 2'(n);
      custom = CUSTOM_BASE + 8'(n);
      @(posedge clk);
      t0 = cyc;
      pressed <= $urandom_range(1) ? (32'h1 << 20) | (32'h1 << (21 + $urandom_range(2)))
                                   : 32'h1 << $urandom_range(31);
      for (n = 0; n < 80000 && starts.size() < 3; n++) @(posedge clk);
      chk_word("first burst", 3 + STROBES * SETTLE_CYC + 5, starts[0] - t0, 1);
      chk_pin("awake in frame", 1'b1, osc_on);
      chk_pin("straps released", 1'b0, lo_oe | hi_oe);
      chk_pin("strobing", 1'b1, $countones(strobes) >= 3);
      for (int i = 0; i < 2; i++)
         chk_word("burst spacing", gap_cyc(i, custom), starts[i + 1] - starts[i], US_CYC);
      // Reset in mid-frame silences the output and returns to standby.
      rstn <= 1'b0;
      pressed <= 32'h0;
      repeat (2) @(posedge clk);
      chk_pin("out in reset", 1'b0, ir_out);
      chk_pin("awake in reset", 1'b0, osc_on);
      rstn <= 1'b1;
      starts.delete();
      repeat (300) @(posedge clk);
      chk_pin("asleep after reset", 1'b0, osc_on);
      chk_pin("no burst after reset", 1'b1, starts.size() == 0);
      final_report();
   end
endmodule : ir_remote_key_encoder_tb
